// *** design/acsb_pkg.sv ***
// constants shared by the amplifier control and status byte bank
package acsb_pkg;

  // --------------------------------------------------------------
  // transfer shape
  // --------------------------------------------------------------
  localparam int unsigned    CTRL_BYTES    = 3;       // bytes per write
  localparam int unsigned    STAT_BYTES    = 2;       // bytes per read
  localparam logic [1:0]     WCNT_FULL     = 2'h3;    // three bytes seen
  localparam logic           DIR_WRITE     = 1'h0;    // direction bit
  localparam logic           DIR_READ      = 1'h1;
  localparam int unsigned    SYNC_STAGES   = 2;

  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [7:0]     CTRL_RESET    = 8'h00;
  localparam logic [7:0]     STAT_RESET    = 8'h00;
  localparam logic [7:0]     RD_IDLE_DATA  = 8'h00;   // beyond two bytes

  // --------------------------------------------------------------
  // control byte one fields
  // --------------------------------------------------------------
  localparam int unsigned    C1_OPERATE    = 0;  // 0 standby
  localparam int unsigned    C1_CH_DIS     = 1;  // 1 channel one off
  localparam int unsigned    C1_OSC_UP     = 3;  // 1 plus ten percent
  localparam int unsigned    C1_HOP_EN     = 4;
  localparam int unsigned    C1_CLIP_OFF   = 5;
  localparam int unsigned    C1_MON_OFF    = 6;
  localparam int unsigned    C1_FAULT_FLAG_PIN_OFF   = 7;  // offset not on fault pin

  // --------------------------------------------------------------
  // control byte two fields
  // --------------------------------------------------------------
  localparam int unsigned    C2_MUTE_ALL   = 0;
  localparam int unsigned    C2_CH_DIS     = 1;
  localparam int unsigned    C2_DC_DET_EN  = 2;
  localparam int unsigned    C2_WARN_LOW   = 3;  // 1 lower threshold
  localparam int unsigned    C2_WARN_OFF   = 4;  // no warning on clip pin
  localparam int unsigned    C2_CLIP_OFF   = 5;
  localparam int unsigned    C2_MON_OFF    = 6;
  localparam int unsigned    C2_PROT_OFF   = 7;

  // --------------------------------------------------------------
  // control byte three fields
  // --------------------------------------------------------------
  localparam int unsigned    C3_MOD_3LVL   = 0;
  localparam int unsigned    C3_PHASE_LO   = 1;
  localparam int unsigned    C3_PHASE_HI   = 3;
  localparam int unsigned    C3_AC_DET_EN  = 4;
  localparam int unsigned    C3_STRAP_NOW  = 7;
  localparam logic [2:0]     PHASE_MAX     = 3'h5;  // 6 and 7 undefined

  // --------------------------------------------------------------
  // status byte fields (byte one / byte two)
  // --------------------------------------------------------------
  localparam int unsigned    S_GND_SHORT   = 0;
  localparam int unsigned    S_SUP_SHORT   = 1;
  localparam int unsigned    S_OFFSET      = 2;  // byte two reserved
  localparam int unsigned    S_LOAD_SHORT  = 3;
  localparam int unsigned    S_OPEN_LOAD   = 4;
  localparam int unsigned    S_VOLT        = 5;  // over / under voltage
  localparam int unsigned    S_VALID_WARN  = 6;  // dc valid / pre-warning
  localparam int unsigned    S_ZERO_TEMP   = 7;  // all-zero / max temp

endpackage

// *** design/acsb_regs.sv ***
// control and diagnostic byte bank of a two-channel class-d amplifier
//
// Functional notes
// - write takes exactly three control bytes, in order
// - offset to fault pin; offset protection enable
// - per-channel offset monitoring, zero means on
// - per-channel clip report on clip pin
// - thermal pre-warning on clip pin when zero
// - ac load detection enabled when one
// - oscillator trim and frequency hopping bits
// - pre-warning threshold select, one means lower
// - three-bit phase shift code, six codes defined
// - standby, mute all, modulation type bits
// - read returns status byte one then two
// - short and offset flags latch until read
// - read clears all but open-load bits, the dc valid bit and the all-zero bit
// - status bits reset to zero, except the all-zero bit, which reads one
// - paralleled channels report in byte one only
// - all-zero bit set; drives fault pin high
// - dc valid bit and pre-warning bit
// - max temperature, overvoltage, undervoltage flags
// - bit four per channel marks open load
// - bit three per channel marks shorted load
// - ground short, supply short, offset bits
// - strap latch now, or at first switching
// - dc detection enable bit, host clears it
// - dc valid cleared on voltage event or hang
`timescale 1ns/1ps

// --------------------------------------------------------------
// two-flop synchroniser, one per crossing group
// --------------------------------------------------------------
module acsb_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first flop feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // acsb_sync

module acsb_regs (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // byte link from the bus framer, on link_clk
  input  wire logic       link_clk,
  input  wire logic       link_reset,
  input  wire logic       link_start,
  input  wire logic       link_dir,
  input  wire logic       link_wr_valid,
  input  wire logic [7:0] link_wr_data,
  input  wire logic       link_rd_next,
  input  wire logic       link_stop,
  output logic      [7:0] link_rd_data,
  output logic            link_rd_ready,
  // diagnostic sources from the power stage (asynchronous)
  input  wire logic [1:0] gnd_short_in,
  input  wire logic [1:0] sup_short_in,
  input  wire logic [1:0] load_short_in,
  input  wire logic [1:0] open_load_in,
  input  wire logic [1:0] offset_in,
  input  wire logic [1:0] clip_in,
  input  wire logic       ac_load_in,
  input  wire logic       overvolt_in,
  input  wire logic       undervolt_in,
  input  wire logic       overtemp_in,
  input  wire logic       prewarn_in,
  input  wire logic       dc_valid_in,
  input  wire logic       amp_hang_in,
  input  wire logic       switching_in,
  input  wire logic       parallel_in,
  input  wire logic [2:0] address_strap_pin,
  input  wire logic [2:0] config_strap_pin,
  // control outputs
  output logic            operate,
  output logic            mute_all,
  output logic      [1:0] channel_enable,
  output logic            osc_trim_up,
  output logic            freq_hop_enable,
  output logic            prewarn_low_threshold,
  output logic            offset_prot_enable,
  output logic            dc_detect_enable,
  output logic            ac_detect_enable,
  output logic      [2:0] phase_code,
  output logic            phase_code_valid,
  output logic            three_level_modulation,
  output logic      [2:0] address_strap_latched,
  output logic      [2:0] config_strap_latched,
  output logic            strap_latched,
  output logic            fault_flag_pin,
  output logic            clip_flag_pin
);

  // --------------------------------------------------------------
  // link domain
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    L_IDLE  = 3'b001,
    L_WRITE = 3'b010,
    L_READ  = 3'b100
  } acsb_lstate_type;

  acsb_lstate_type lstate_r;
  acsb_lstate_type lstate_nxt;
  logic [1:0]      wcnt_r;
  logic            wover_r;
  localparam int unsigned CTRL_BYTES = acsb_pkg::CTRL_BYTES;
  logic [7:0]      cap_r [CTRL_BYTES];
  logic [23:0]     shadow_r;         // stable between commits
  logic            wr_tog_r;
  logic            rq_tog_r;
  logic            clr_tog_r;
  logic            ack_seen_r;
  logic            ack_sync;
  logic            rd_idx_r;
  logic [7:0]      rd_b2_r;
  logic            rd_ready_r;
  logic [7:0]      rd_data_r;
  logic [7:0]      snap1_r;
  logic [7:0]      snap2_r;
  logic            ack_tog_r;

  wire ack_edge   = ack_sync ^ ack_seen_r;
  wire wr_commit  = (lstate_r == L_WRITE) && link_stop &&
                    (wcnt_r == acsb_pkg::WCNT_FULL) && !wover_r;
  wire rd_commit  = (lstate_r == L_READ) && link_stop && rd_ready_r;
  wire open_write = link_start && (link_dir == acsb_pkg::DIR_WRITE);
  wire open_read  = link_start && (link_dir == acsb_pkg::DIR_READ);

  // transfer state follows start and stop
  always_comb
  begin
    lstate_nxt = lstate_r;
    case (lstate_r)
      L_IDLE, L_WRITE, L_READ:
      begin
        if (open_write)
          lstate_nxt = L_WRITE;
        else if (open_read)
          lstate_nxt = L_READ;
        else if (link_stop)
          lstate_nxt = L_IDLE;
      end
      default: lstate_nxt = L_IDLE;
    endcase
  end

  always_ff @(posedge link_clk)
  begin
    if (link_reset)
      lstate_r <= L_IDLE;
    else
      lstate_r <= lstate_nxt;
  end

  // collect control bytes; only a clean three-byte write commits
  always_ff @(posedge link_clk)
  begin
    if (link_reset)
    begin
      wcnt_r   <= 2'h0;
      wover_r  <= 1'h0;
      shadow_r <= 24'h000000;
      wr_tog_r <= 1'h0;
      for (int i = 0; i < CTRL_BYTES; i++)
        cap_r[i] <= acsb_pkg::CTRL_RESET;
    end
    else
    begin
      if (open_write)
      begin
        wcnt_r  <= 2'h0;
        wover_r <= 1'h0;
      end
      else if (lstate_r == L_WRITE && link_wr_valid)
      begin
        if (wcnt_r == acsb_pkg::WCNT_FULL)
          wover_r <= 1'h1;
        else
        begin
          cap_r[wcnt_r] <= link_wr_data;
          wcnt_r        <= wcnt_r + 2'h1;
        end
      end
      if (wr_commit)
      begin
        shadow_r <= {cap_r[2], cap_r[1], cap_r[0]};
        wr_tog_r <= ~wr_tog_r;
      end
    end
  end

  // read: ask the core for a snapshot, then stream two bytes
  always_ff @(posedge link_clk)
  begin
    if (link_reset)
    begin
      rq_tog_r   <= 1'h0;
      clr_tog_r  <= 1'h0;
      ack_seen_r <= 1'h0;
      rd_idx_r   <= 1'h0;
      rd_b2_r    <= acsb_pkg::STAT_RESET;
      rd_ready_r <= 1'h0;
      rd_data_r  <= acsb_pkg::RD_IDLE_DATA;
    end
    else
    begin
      ack_seen_r <= ack_sync;
      if (open_read)
      begin
        rq_tog_r   <= ~rq_tog_r;
        rd_ready_r <= 1'h0;
        rd_idx_r   <= 1'h0;
      end
      else if (ack_edge && lstate_r == L_READ)
      begin
        rd_data_r  <= snap1_r;
        rd_b2_r    <= snap2_r;
        rd_ready_r <= 1'h1;
      end
      else if (link_rd_next && rd_ready_r)
      begin
        rd_idx_r  <= 1'h1;
        rd_data_r <= rd_idx_r ? acsb_pkg::RD_IDLE_DATA : rd_b2_r;
      end
      if (rd_commit)
      begin
        clr_tog_r  <= ~clr_tog_r;
        rd_ready_r <= 1'h0;
        rd_data_r  <= acsb_pkg::RD_IDLE_DATA;
      end
    end
  end

  assign link_rd_data  = rd_data_r;
  assign link_rd_ready = rd_ready_r;

  acsb_sync #(.W(1)) u_ack_sync (
    .clk (link_clk),
    .rst (link_reset),
    .d   (ack_tog_r),
    .q   (ack_sync)
  );

  // --------------------------------------------------------------
  // core domain: crossings in
  // --------------------------------------------------------------
  localparam int unsigned PW = 34;
  logic [PW-1:0] pins_s;
  logic [2:0]    tog_s;
  logic [2:0]    tog_seen_r;

  acsb_sync #(.W(PW)) u_pin_sync (
    .clk (ref_clk),
    .rst (reset),
    .d   ({gnd_short_in, sup_short_in, load_short_in, open_load_in,
           offset_in, clip_in, ac_load_in, overvolt_in, undervolt_in,
           overtemp_in, prewarn_in, dc_valid_in, amp_hang_in,
           switching_in, parallel_in, address_strap_pin,
           config_strap_pin, 7'h00}),
    .q   (pins_s)
  );

  acsb_sync #(.W(3)) u_tog_sync (
    .clk (ref_clk),
    .rst (reset),
    .d   ({wr_tog_r, rq_tog_r, clr_tog_r}),
    .q   (tog_s)
  );

  // named views of the synchronised pins
  wire [1:0] gnd_s   = pins_s[33:32];
  wire [1:0] sup_s   = pins_s[31:30];
  wire [1:0] lsh_s   = pins_s[29:28];
  wire [1:0] open_s  = pins_s[27:26];
  wire [1:0] off_s   = pins_s[25:24];
  wire [1:0] clip_s  = pins_s[23:22];
  wire       ac_s    = pins_s[21];
  wire       ov_s    = pins_s[20];
  wire       uv_s    = pins_s[19];
  wire       ot_s    = pins_s[18];
  wire       pw_s    = pins_s[17];
  wire       dcv_s   = pins_s[16];
  wire       hang_s  = pins_s[15];
  wire       sw_s    = pins_s[14];
  wire       par_s   = pins_s[13];
  wire [2:0] ads_s   = pins_s[12:10];
  wire [2:0] mod_s   = pins_s[9:7];

  wire wr_evt  = tog_s[2] ^ tog_seen_r[2];
  wire rq_evt  = tog_s[1] ^ tog_seen_r[1];
  wire clr_evt = tog_s[0] ^ tog_seen_r[0];

  // --------------------------------------------------------------
  // core domain: control bytes
  // --------------------------------------------------------------
  logic [7:0] cb1_r;
  logic [7:0] cb2_r;
  logic [7:0] cb3_r;
  logic       sw_seen_r;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tog_seen_r <= 3'h0;
      cb1_r      <= acsb_pkg::CTRL_RESET;
      cb2_r      <= acsb_pkg::CTRL_RESET;
      cb3_r      <= acsb_pkg::CTRL_RESET;
    end
    else
    begin
      tog_seen_r <= tog_s;
      if (wr_evt)
      begin
        cb1_r <= shadow_r[7:0];
        cb2_r <= shadow_r[15:8];
        cb3_r <= shadow_r[23:16];
      end
    end
  end

  // decoded controls straight from the control flops
  assign operate            = cb1_r[acsb_pkg::C1_OPERATE];
  assign mute_all           = cb2_r[acsb_pkg::C2_MUTE_ALL];
  assign three_level_modulation = cb3_r[acsb_pkg::C3_MOD_3LVL];
  assign channel_enable     = {~cb2_r[acsb_pkg::C2_CH_DIS],
                               ~cb1_r[acsb_pkg::C1_CH_DIS]};
  assign osc_trim_up        = cb1_r[acsb_pkg::C1_OSC_UP];
  assign freq_hop_enable    = cb1_r[acsb_pkg::C1_HOP_EN];
  assign prewarn_low_threshold = cb2_r[acsb_pkg::C2_WARN_LOW];
  assign offset_prot_enable = ~cb2_r[acsb_pkg::C2_PROT_OFF];
  assign dc_detect_enable   = cb2_r[acsb_pkg::C2_DC_DET_EN];
  assign ac_detect_enable   = cb3_r[acsb_pkg::C3_AC_DET_EN];
  assign phase_code         = cb3_r[acsb_pkg::C3_PHASE_HI:
                                    acsb_pkg::C3_PHASE_LO];
  assign phase_code_valid   = (phase_code <= acsb_pkg::PHASE_MAX);

  // strap capture: on demand, else at the first switching edge
  wire strap_take = !strap_latched &&
                    (cb3_r[acsb_pkg::C3_STRAP_NOW] ||
                     (sw_s && !sw_seen_r));

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sw_seen_r             <= 1'h0;
      strap_latched         <= 1'h0;
      address_strap_latched <= 3'h0;
      config_strap_latched  <= 3'h0;
    end
    else
    begin
      sw_seen_r <= sw_s;
      if (strap_take)
      begin
        strap_latched         <= 1'h1;
        address_strap_latched <= ads_s;
        config_strap_latched  <= mod_s;
      end
    end
  end

  // --------------------------------------------------------------
  // core domain: status bytes
  // --------------------------------------------------------------
  logic [7:0] st1_r;       // sticky flags, byte one
  logic [7:0] st2_r;       // sticky flags, byte two
  logic       dcv_r;
  logic [1:0] open_r;

  // offset detect only from monitored channels
  wire off_det = (off_s[0] & ~cb1_r[acsb_pkg::C1_MON_OFF]) |
                 (off_s[1] & ~cb2_r[acsb_pkg::C2_MON_OFF]);
  // paralleled: both channels fold into byte one
  wire [2:0] ch1_f = {lsh_s[0], sup_s[0], gnd_s[0]} |
                     ({3{par_s}} & {lsh_s[1], sup_s[1], gnd_s[1]});
  wire [2:0] ch2_f = {3{~par_s}} & {lsh_s[1], sup_s[1], gnd_s[1]};
  wire [7:0] set1  = {2'h0, ov_s, 1'h0, ch1_f[2], off_det,
                      ch1_f[1:0]};
  wire [7:0] set2  = {ot_s, pw_s, uv_s, 1'h0, ch2_f[2], 1'h0,
                      ch2_f[1:0]};
  // a read clears exactly what it reported; a new set wins
  wire [7:0] clr1  = clr_evt ? snap1_r : 8'h00;
  wire [7:0] clr2  = clr_evt ? snap2_r : 8'h00;
  wire [7:0] st1_nxt = set1 | (st1_r & ~clr1);
  wire [7:0] st2_nxt = set2 | (st2_r & ~clr2);
  // detection valid: interruption forces it low
  wire dc_abort  = uv_s | ov_s | hang_s;
  wire dcv_nxt   = (dcv_r | dcv_s) & ~dc_abort;
  wire all_zero  = ~|{cb1_r, cb2_r, cb3_r};
  wire open1     = par_s ? |open_r : open_r[0];
  wire open2     = ~par_s & open_r[1];
  wire [7:0] stat1 = {all_zero, dcv_r, st1_r[5], open1,
                      st1_r[3:0]};
  wire [7:0] stat2 = {st2_r[7:5], open2, st2_r[3:0]};

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st1_r     <= acsb_pkg::STAT_RESET;
      st2_r     <= acsb_pkg::STAT_RESET;
      dcv_r     <= 1'h0;
      open_r    <= 2'h0;
      snap1_r   <= acsb_pkg::STAT_RESET;
      snap2_r   <= acsb_pkg::STAT_RESET;
      ack_tog_r <= 1'h0;
    end
    else
    begin
      st1_r <= st1_nxt;
      st2_r <= st2_nxt;
      dcv_r <= dcv_nxt;
      if (dcv_s)
        open_r <= open_s;
      if (rq_evt)
      begin
        snap1_r   <= stat1;
        snap2_r   <= stat2;
        ack_tog_r <= ~ack_tog_r;
      end
    end
  end

  // --------------------------------------------------------------
  // flag pins, registered
  // --------------------------------------------------------------
  wire fault_flag_pin_nxt = all_zero |
                  (st1_r[acsb_pkg::S_OFFSET] &
                   ~cb1_r[acsb_pkg::C1_FAULT_FLAG_PIN_OFF]);
  wire clip_nxt = (clip_s[0] & ~cb1_r[acsb_pkg::C1_CLIP_OFF]) |
                  (clip_s[1] & ~cb2_r[acsb_pkg::C2_CLIP_OFF]) |
                  (pw_s & ~cb2_r[acsb_pkg::C2_WARN_OFF]) |
                  (ac_s & cb3_r[acsb_pkg::C3_AC_DET_EN]);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      fault_flag_pin <= 1'h1;
      clip_flag_pin  <= 1'h0;
    end
    else
    begin
      fault_flag_pin <= fault_flag_pin_nxt;
      clip_flag_pin  <= clip_nxt;
    end
  end

endmodule // acsb_regs

// *** test/acsb_monitor.sv ***
// port checker for the amplifier control and status byte bank
`timescale 1ns/1ps
// ------------------------------------------------------------
// checker
// ------------------------------------------------------------
module acsb_monitor (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       link_clk,
  input wire logic       link_reset,
  input wire logic       link_start,
  input wire logic       link_dir,
  input wire logic       link_stop,
  input wire logic [7:0] link_rd_data,
  input wire logic       link_rd_ready,
  input wire logic [1:0] clip_in,
  input wire logic       prewarn_in,
  input wire logic       ac_load_in,
  input wire logic       switching_in,
  input wire logic [2:0] phase_code,
  input wire logic       phase_code_valid,
  input wire logic [2:0] address_strap_latched,
  input wire logic [2:0] config_strap_latched,
  input wire logic       strap_latched,
  input wire logic       fault_flag_pin,
  input wire logic       clip_flag_pin
);
  // clip sources idle
  sequence quiet_s;
    (clip_in == 2'h0 && !prewarn_in && !ac_load_in) [*5];
  endsequence
  sequence read_req_s;
    link_start && link_dir;
  endsequence

  fault_reset_a : assert property (
    @(posedge ref_clk) disable iff (reset) $fell(reset) |-> fault_flag_pin)
    else $error("fault pin low after reset");
  clip_quiet_a : assert property (
    @(posedge ref_clk) disable iff (reset) quiet_s |-> !clip_flag_pin)
    else $error("clip pin high with no source");
  phase_valid_a : assert property (
    @(posedge ref_clk) disable iff (reset)
    phase_code_valid == (phase_code <= 3'h5)) else $error("phase flag wrong");
  strap_hold_a : assert property (
    @(posedge ref_clk) disable iff (reset) strap_latched |=> strap_latched
    && $stable(address_strap_latched) && $stable(config_strap_latched))
    else $error("strap values moved");
  strap_switch_a : assert property (
    @(posedge ref_clk) disable iff (reset) switching_in [*6] |-> strap_latched)
    else $error("strap not latched on switching");
  ready_rise_a : assert property (
    @(posedge link_clk) disable iff (link_reset)
    read_req_s |-> ##[1:6] link_rd_ready) else $error("read not ready");
  ready_hold_a : assert property (
    @(posedge link_clk) disable iff (link_reset)
    link_rd_ready && !link_stop |=> link_rd_ready) else $error("ready lost");
  read_idle_a : assert property (
    @(posedge link_clk) disable iff (link_reset) !link_rd_ready &&
    !$past(link_rd_ready) |-> link_rd_data == 8'h00)
    else $error("read data not idle");
endmodule // acsb_monitor

bind acsb_regs acsb_monitor mon_u (
  .ref_clk, .reset, .link_clk, .link_reset, .link_start, .link_dir,
  .link_stop, .link_rd_data, .link_rd_ready, .clip_in, .prewarn_in,
  .ac_load_in, .switching_in, .phase_code, .phase_code_valid,
  .address_strap_latched, .config_strap_latched, .strap_latched,
  .fault_flag_pin, .clip_flag_pin
);

// *** test/acsb_host_model.sv ***
// bus host model driving the byte link of the control bank
`timescale 1ns/1ps
// ------------------------------------------------------------
// host
// ------------------------------------------------------------
module acsb_host_model (
  input  wire logic       link_clk,
  input  wire logic [7:0] link_rd_data,
  input  wire logic       link_rd_ready,
  output logic            link_start,
  output logic            link_dir,
  output logic            link_wr_valid,
  output logic      [7:0] link_wr_data,
  output logic            link_rd_next,
  output logic            link_stop
);
  // idle link at time zero
  initial
  begin
    {link_start, link_dir, link_wr_valid, link_rd_next, link_stop} = 5'h00;
    link_wr_data = 8'h00;
  end

  // write n bytes, top byte of d first
  task automatic wr(input int n, input logic [31:0] d);
    @(posedge link_clk);
    {link_start, link_dir} <= 2'h2;
    for (int i = 0; i < n; i++)
    begin
      @(posedge link_clk);
      link_start <= 1'b0;
      {link_wr_valid, link_wr_data} <= {1'b1, d[31-8*i -: 8]}; // order
    end
    @(posedge link_clk);
    {link_start, link_wr_valid, link_stop} <= 3'h1;
    link_wr_data <= ~link_wr_data; // released data shows no stale byte
    @(posedge link_clk);
    link_stop <= 1'b0;
  endtask

  // read both status bytes, one first
  task automatic rd(output logic [7:0] s1, output logic [7:0] s2);
    int w;
    @(posedge link_clk);
    {link_start, link_dir} <= 2'h3;
    @(posedge link_clk);
    {link_start, link_dir} <= 2'h0;
    w = 0;
    while (link_rd_ready !== 1'b1 && w < 20)
    begin
      @(posedge link_clk);
      w++;
    end
    s1 = link_rd_data;
    link_rd_next <= 1'b1;
    @(posedge link_clk);
    link_rd_next <= 1'b0;
    @(posedge link_clk);
    s2 = link_rd_data;
    link_stop <= 1'b1;
    @(posedge link_clk);
    link_stop <= 1'b0;
  endtask
endmodule // acsb_host_model

// *** test/tb_top.sv ***
// self-checking bench for the control and status byte bank
`timescale 1ns/1ps
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module tb_top;
  logic       ref_clk = 1'b0, reset = 1'b1, link_clk = 1'b0, link_reset = 1'b1;
  logic       link_start, link_dir, link_wr_valid, link_rd_next, link_stop;
  logic [7:0] link_wr_data, link_rd_data, r1, r2, r3;
  logic [1:0] gnd_short_in = 2'h0, sup_short_in = 2'h0, load_short_in = 2'h0;
  logic [1:0] open_load_in = 2'h0, offset_in = 2'h0, clip_in = 2'h0;
  logic       ac_load_in = 1'b0, overvolt_in = 1'b0, undervolt_in = 1'b0;
  logic       overtemp_in = 1'b0, prewarn_in = 1'b0, dc_valid_in = 1'b0;
  logic       amp_hang_in = 1'b0, switching_in = 1'b0, parallel_in = 1'b0;
  logic [2:0] address_strap_pin = 3'h5, config_strap_pin = 3'h2;
  logic       operate, mute_all, osc_trim_up, freq_hop_enable, link_rd_ready;
  logic       prewarn_low_threshold, offset_prot_enable, dc_detect_enable;
  logic       ac_detect_enable, phase_code_valid, three_level_modulation;
  logic       strap_latched, fault_flag_pin, clip_flag_pin;
  logic [1:0] channel_enable;
  logic [2:0] phase_code, address_strap_latched, config_strap_latched;
  logic [23:0] exp_q[$], res, cur;
  int         compares = 0, miscompares = 0;
  event       res_ev;
  wire [23:0] ctl_obs = {7'h00, fault_flag_pin, clip_flag_pin, operate,
    mute_all, channel_enable, osc_trim_up, freq_hop_enable,
    prewarn_low_threshold, offset_prot_enable, dc_detect_enable,
    ac_detect_enable, phase_code, phase_code_valid, three_level_modulation};
  wire [23:0] strap_obs = {17'h0, strap_latched, address_strap_latched,
    config_strap_latched};

  // clocks, link unrelated in phase
  always #2 ref_clk = ~ref_clk;
  initial
  begin
    #13.1;
    forever #40 link_clk = ~link_clk;
  end

  acsb_regs dut_u (.*);
  acsb_host_model host_u (.link_clk, .link_rd_data, .link_rd_ready,
    .link_start, .link_dir, .link_wr_valid, .link_wr_data, .link_rd_next,
    .link_stop);

  // expected outputs from the rules
  function automatic logic [23:0] ctl(logic [7:0] a, b, c, logic off);
    ctl = {7'h00, ((a | b | c) == 8'h00) | (off & ~a[7]),
      (clip_in[0] & ~a[5]) | (clip_in[1] & ~b[5]) | (prewarn_in & ~b[4])
      | (ac_load_in & c[4]), a[0], b[0], ~b[1], ~a[1], a[3], a[4], b[3],
      ~b[7], b[2], c[4], c[3:1], c[3:1] <= 3'h5, c[0]};
  endfunction

  task automatic note(input logic [23:0] e, input logic [23:0] g);
    exp_q.push_back(e);
    res = g;
    -> res_ev;
    #1;
  endtask

  task automatic wr_chk(input logic [7:0] a, b, c);
    host_u.wr(3, {a, b, c, 8'h00});
    repeat (10) @(posedge ref_clk);
    note(ctl(a, b, c, 1'b0), ctl_obs);
  endtask

  task automatic rd_chk(input logic [7:0] a, b);
    logic [7:0] s1, s2;
    host_u.rd(s1, s2);
    note({8'h00, a, b}, {8'h00, s1, s2});
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // result watcher
  always @(res_ev)
  begin
    cur = exp_q.pop_front();
    compares++;
    if (res !== cur)
    begin
      miscompares++;
      $display("Error at %0t expected %h got %h", $time, cur, res);
    end
  end

  // main sequence
  initial
  begin
    void'($urandom(59));
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge link_clk);
    link_reset <= 1'b0;
    repeat (2) @(posedge link_clk);
    rd_chk(8'h80, 8'h00); // reset status
    wr_chk(8'h02, 8'h06, 8'h80); // strap latch command
    note({17'h0, 7'h6A}, strap_obs); // strap captured
    wr_chk(8'h01, 8'h00, 8'h00); // operate only
    @(posedge ref_clk);
    {gnd_short_in, sup_short_in, load_short_in, offset_in} <= 8'h69;
    {dc_valid_in, open_load_in} <= 3'h7;
    repeat (5) @(posedge ref_clk);
    {gnd_short_in, sup_short_in, load_short_in, offset_in} <= 8'h00;
    repeat (6) @(posedge ref_clk);
    note(ctl(8'h01, 8'h00, 8'h00, 1'b1), ctl_obs); // offset on pin
    rd_chk(8'h55, 8'h1A); // latched flags
    rd_chk(8'h50, 8'h10); // cleared but open-load and dc valid bits
    note(ctl(8'h01, 8'h00, 8'h00, 1'b0), ctl_obs); // offset gone
    parallel_in <= 1'b1;
    gnd_short_in <= 2'h2;
    repeat (5) @(posedge ref_clk);
    gnd_short_in <= 2'h0;
    repeat (6) @(posedge ref_clk);
    rd_chk(8'h51, 8'h00); // paralleled report
    parallel_in <= 1'b0;
    dc_valid_in <= 1'b0;
    {overvolt_in, undervolt_in, overtemp_in} <= 3'h7;
    repeat (6) @(posedge ref_clk);
    rd_chk(8'h30, 8'hB0); // valid bit aborted
    {overvolt_in, undervolt_in, overtemp_in} <= 3'h0;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge ref_clk);
      {clip_in, prewarn_in, ac_load_in} <= 4'($urandom);
      {address_strap_pin, config_strap_pin} <= 6'($urandom);
      r1 = 8'($urandom) & 8'hFB; // undefined bit kept zero
      r2 = 8'($urandom) & 8'hFB; // detection left cleared
      r3 = 8'($urandom) & 8'h1F;
      wr_chk(r1, r2, r3); // fields
      host_u.wr(2, 32'hFFFF_FF00); // short write dropped
      host_u.wr(4, 32'h0102_0304); // long write dropped
      repeat (10) @(posedge ref_clk);
      note(ctl(r1, r2, r3, 1'b0), ctl_obs); // outputs held
    end
    wr_chk(8'h00, 8'h00, 8'h00); // all zero again
    note({17'h0, 7'h6A}, strap_obs); // strap kept
    {reset, link_reset} <= 2'h3; // second reset frees straps
    repeat (2) @(posedge link_clk);
    {reset, link_reset} <= 2'h0;
    switching_in <= 1'b1;
    repeat (10) @(posedge ref_clk);
    note({18'h1, address_strap_pin, config_strap_pin}, strap_obs);
    finish_test();
  end

  // watchdog
  initial
  begin
    #200000;
    miscompares++;
    finish_test();
  end
endmodule // tb_top
